// ==== hdl/arch_regs_pkg.sv ====
// package for the architectural register block: register map, reset values, flag positions
// assumes a single 100 MHz core clock and a plain strobe register port
`default_nettype none
package arch_regs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // register port offsets (index into the architectural file)
  localparam logic [4:0] OFS_ACCUM = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h01;
  localparam logic [4:0] OFS_DATAX = 5'h02;
  localparam logic [4:0] OFS_BASE = 5'h03;
  localparam logic [4:0] OFS_STACKP = 5'h04;
  localparam logic [4:0] OFS_BASEP = 5'h05;
  localparam logic [4:0] OFS_SRCIDX = 5'h06;
  localparam logic [4:0] OFS_DESTIDX = 5'h07;
  localparam logic [4:0] OFS_CODESEG = 5'h08;
  localparam logic [4:0] OFS_STACKSEG = 5'h09;
  localparam logic [4:0] OFS_DATASEG = 5'h0A;
  localparam logic [4:0] OFS_EXTRASEG = 5'h0B;
  localparam logic [4:0] OFS_IPTR = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h0D;
  localparam logic [4:0] OFS_LOWBYTE = 5'h10; // 0x10..0x13: low halves of data regs
  localparam logic [4:0] OFS_HIGHBYTE = 5'h14; // 0x14..0x17: high halves of data regs
  // reset values
  localparam logic [15:0] CODESEG_RST = 16'hFFFF;
  localparam logic [15:0] SEG_RST = 16'h0000;
  localparam logic [15:0] IPTR_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'hF000;
  // status word bit positions
  localparam int unsigned CF_BIT = 0;
  localparam int unsigned PF_BIT = 2;
  localparam int unsigned AF_BIT = 4;
  localparam int unsigned ZF_BIT = 6;
  localparam int unsigned SF_BIT = 7;
  localparam int unsigned TF_BIT = 8;
  localparam int unsigned IF_BIT = 9;
  localparam int unsigned DF_BIT = 10;
  localparam int unsigned OF_BIT = 11;
  localparam logic [15:0] STATUS_WMASK = 16'h0FD5; // writable flag bits
  // alu operations
  typedef enum logic [5:0] {
    ALU_ADD = 6'b000001,
    ALU_SUB = 6'b000010,
    ALU_AND = 6'b000100,
    ALU_OR = 6'b001000,
    ALU_XOR = 6'b010000,
    ALU_RCL = 6'b100000
  } alu_op_t;
endpackage : arch_regs_pkg
`default_nettype wire

// ==== hdl/general_reg_mem.sv ====
// eight 16-bit general registers with byte-lane writes and a registered read port
// assumes the caller gives one write and one read address per cycle; no reset by design
`default_nettype none
module general_reg_mem (
  input wire logic clk_sys,
  input wire logic [2:0] wrAddr,
  input wire logic [1:0] wrLane,
  input wire logic [15:0] wrData,
  input wire logic [2:0] rdAddr,
  output logic [15:0] rdData
);
  logic [15:0] mem [0:7];

  // byte lanes written independently; contents undefined after reset
  always_ff @(posedge clk_sys) begin
    if (wrLane[0]) begin
      mem[wrAddr][7:0] <= wrData[7:0];
    end
    if (wrLane[1]) begin
      mem[wrAddr][15:8] <= wrData[15:8];
    end
  end

  // registered read
  always_ff @(posedge clk_sys) begin
    rdData <= mem[rdAddr];
  end
endmodule : general_reg_mem
`default_nettype wire

// ==== hdl/flag_alu.sv ====
// 8/16-bit arithmetic unit producing result and the six status flags
// assumes operands already aligned in the low bits for byte operations
`default_nettype none
module flag_alu
  import arch_regs_pkg::*;
(
  input wire alu_op_t op,
  input wire logic byteMode,
  input wire logic [15:0] opA,
  input wire logic [15:0] opB,
  input wire logic carryIn,
  output logic [15:0] result,
  output logic carryOut,
  output logic auxOut,
  output logic overflowOut,
  output logic signOut,
  output logic parityOut,
  output logic zeroOut
);
  logic [16:0] sum;
  logic [15:0] r;
  logic msbA;
  logic msbB;
  logic msbR;

  // operation, carry and overflow per width
  always_comb begin
    sum = 17'h00000;
    r = 16'h0000;
    carryOut = 1'b0;
    overflowOut = 1'b0;
    case (op)
      ALU_ADD: sum = {1'b0, opA} + {1'b0, opB};
      ALU_SUB: sum = {1'b0, opA} - {1'b0, opB};
      default: sum = 17'h00000;
    endcase
    case (op)
      ALU_ADD, ALU_SUB: r = sum[15:0];
      ALU_AND: r = opA & opB;
      ALU_OR: r = opA | opB;
      ALU_XOR: r = opA ^ opB;
      ALU_RCL: r = byteMode ? {8'h00, opA[6:0], carryIn} : {opA[14:0], carryIn};
      default: r = 16'h0000;
    endcase
    if (byteMode) begin
      r = {8'h00, r[7:0]};
    end
    msbA = byteMode ? opA[7] : opA[15];
    msbB = byteMode ? opB[7] : opB[15];
    msbR = byteMode ? r[7] : r[15];
    case (op)
      // carry out of / borrow into the top bit of the 8- or 16-bit result
      ALU_ADD, ALU_SUB: carryOut = byteMode ? (opA[8] ^ opB[8] ^ sum[8]) : sum[16]; // RULE11
      ALU_RCL: carryOut = msbA; // RULE11
      default: carryOut = 1'b0;
    endcase
    case (op)
      // signed result too large for the destination
      ALU_ADD: overflowOut = (msbA == msbB) && (msbR != msbA); // RULE12
      ALU_SUB: overflowOut = (msbA != msbB) && (msbR != msbA); // RULE12
      default: overflowOut = 1'b0;
    endcase
    result = r;
    auxOut = (op == ALU_ADD || op == ALU_SUB) ? (opA[4] ^ opB[4] ^ r[4]) : 1'b0; // RULE10
    signOut = msbR; // RULE13
    parityOut = ~^r[7:0]; // RULE14
    zeroOut = (r == 16'h0000); // RULE15
  end
endmodule : flag_alu
`default_nettype wire

// ==== hdl/cpu_architectural_registers.sv ====
// architectural register state of a 16-bit core: general, segment, pointer and status registers
// assumes the execution unit drives one operation per cycle and software uses the strobe port
//
// Behaviour
// RULE1 - eight 16-bit general registers: four data, four pointer/index
// RULE2 - data registers accessible as word or as separate high/low bytes
// RULE3 - pointer and index registers accessed only as whole words
// RULE4 - implicit operands: accumulator, data extension, count and its low byte
// RULE5 - general registers have no reset value
// RULE6 - four segment registers give code, stack, data, extra bases
// RULE7 - reset loads code segment all ones, other segments zero
// RULE8 - instruction pointer holds next fetch; saved value is next executed instruction
// RULE9 - reset clears instruction pointer, start address 0FFFF0H
// RULE10 - auxiliary carry on carry or borrow at bit 3
// RULE11 - carry on carry out or borrow into top bit; rotates load it
// RULE12 - overflow on signed overflow; overflow trap raises interrupt when set
// RULE13 - sign flag copies result top bit
// RULE14 - parity flag set for even count of ones
// RULE15 - zero flag set when result is zero
// RULE16 - direction flag set decrements string indexes, clear increments
// RULE17 - interrupt enable gates only maskable requests
// RULE18 - single-step flag interrupts after each completed instruction
// RULE19 - flags live in a 16-bit status word reset to F000
// RULE20 - software writes zero into reserved status bits
// RULE21 - segment bases aligned to sixteen bytes
// RULE22 - physical address is segment shifted four plus offset, carry dropped
// RULE23 - flags at carry 0, parity 2, aux 4, zero 6, sign 7, trap 8, ie 9, dir 10, ov 11
//
// Chosen here: the register offsets and strobed register access.
`default_nettype none
module cpu_architectural_registers
  import arch_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  // software register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // execution unit operation port
  input wire logic aluGo,
  input wire alu_op_t aluOp,
  input wire logic aluByte,
  input wire logic [2:0] aluDest,
  input wire logic [15:0] aluOperand,
  input wire logic stringStep,
  input wire logic loopStep,
  input wire logic instrDone,
  input wire logic [15:0] instrLength,
  input wire logic fetchStep,
  input wire logic overflowTrapInstr,
  // address generation request
  input wire logic [1:0] addrSeg,
  input wire logic [15:0] addrOffset,
  // interrupt recognition
  input wire logic maskableReq,
  input wire logic softIntReq,
  input wire logic nmiReq,
  output logic [19:0] physAddr,
  output logic [19:0] fetchAddr,
  output logic [15:0] savedIptr,
  output logic takeInterrupt,
  output logic singleStepTrap,
  output logic overflowTrap,
  output logic [7:0] shiftCount,
  output logic countZero
);
  logic [15:0] segReg_r [0:3];
  logic [15:0] iptr_r;
  logic [15:0] execIptr_r;
  logic [15:0] status_r;
  logic [15:0] accum_r;
  logic [15:0] count_r;
  logic [15:0] datax_r;
  logic [15:0] srcIdx_r;
  logic [15:0] destIdx_r;
  logic [15:0] memRd;
  logic [2:0] memWrAddr;
  logic [1:0] memWrLane;
  logic [15:0] memWrData;
  logic [2:0] memRdAddr;
  logic rdPend_r;
  logic rdFromMem_r;
  logic [15:0] rdHold_r;
  logic [1:0] rdByte_r;
  logic [15:0] aluRes;
  logic aluC, aluA, aluO, aluS, aluP, aluZ;
  logic [15:0] destVal;
  logic [15:0] stepAmt;

  // general registers 0,1,2,6,7 live in flop mirrors too; steps reach only the mirrors
  function automatic logic [15:0] mirrorOf(input logic [2:0] i);
    case (i)
      3'd0: mirrorOf = accum_r;
      3'd1: mirrorOf = count_r;
      3'd2: mirrorOf = datax_r;
      3'd6: mirrorOf = srcIdx_r;
      3'd7: mirrorOf = destIdx_r;
      default: mirrorOf = 16'h0000;
    endcase
  endfunction : mirrorOf
  function automatic logic isGeneral(input logic [4:0] a);
    isGeneral = (a <= OFS_DESTIDX) || (a >= OFS_LOWBYTE && a <= 5'h17);
  endfunction : isGeneral

  // general register storage; byte addresses only reach data registers 0..3
  general_reg_mem u_mem (
    .clk_sys(clk_sys),
    .wrAddr(memWrAddr),
    .wrLane(memWrLane),
    .wrData(memWrData),
    .rdAddr(memRdAddr),
    .rdData(memRd)
  );

  flag_alu u_alu (
    .op(aluOp),
    .byteMode(aluByte && !aluDest[2]),
    .opA(destVal),
    .opB(aluOperand),
    .carryIn(status_r[CF_BIT]),
    .result(aluRes),
    .carryOut(aluC),
    .auxOut(aluA),
    .overflowOut(aluO),
    .signOut(aluS),
    .parityOut(aluP),
    .zeroOut(aluZ)
  );

  // destination operand for the alu from the mirrored registers
  always_comb begin
    destVal = mirrorOf(aluDest);
  end

  // memory write port: alu results win over software writes
  always_comb begin
    memWrAddr = regAddr[2:0];
    memWrLane = 2'b00;
    memWrData = regWrData;
    memRdAddr = regAddr[2:0];
    if (aluGo) begin
      memWrAddr = aluDest;
      memWrLane = (aluByte && aluDest[2] == 1'b0) ? 2'b01 : 2'b11; // RULE2 RULE3
      memWrData = aluRes;
    end else if (regWrite && regAddr <= OFS_DESTIDX) begin
      memWrLane = 2'b11; // RULE1 RULE3
    end else if (regWrite && regAddr >= OFS_LOWBYTE && regAddr <= 5'h13) begin
      memWrAddr = {1'b0, regAddr[1:0]};
      memWrLane = 2'b01; // RULE2
    end else if (regWrite && regAddr >= OFS_HIGHBYTE && regAddr <= 5'h17) begin
      memWrAddr = {1'b0, regAddr[1:0]};
      memWrLane = 2'b10; // RULE2
      memWrData = {regWrData[7:0], 8'h00};
    end
    if (regAddr >= OFS_LOWBYTE) begin
      memRdAddr = {1'b0, regAddr[1:0]};
    end
  end

  // mirrors of implicit-operand registers; no reset, contents undefined after reset
  always_ff @(posedge clk_sys) begin
    if (memWrLane[0]) begin
      case (memWrAddr)
        3'd0: accum_r[7:0] <= memWrData[7:0]; // RULE4 RULE5
        3'd1: count_r[7:0] <= memWrData[7:0]; // RULE4
        3'd2: datax_r[7:0] <= memWrData[7:0]; // RULE4
        3'd6: srcIdx_r[7:0] <= memWrData[7:0];
        3'd7: destIdx_r[7:0] <= memWrData[7:0];
        default: ;
      endcase
    end
    if (memWrLane[1]) begin
      case (memWrAddr)
        3'd0: accum_r[15:8] <= memWrData[15:8];
        3'd1: count_r[15:8] <= memWrData[15:8];
        3'd2: datax_r[15:8] <= memWrData[15:8];
        3'd6: srcIdx_r[15:8] <= memWrData[15:8];
        3'd7: destIdx_r[15:8] <= memWrData[15:8];
        default: ;
      endcase
    end
    if (!aluGo && memWrLane == 2'b00) begin
      // loops count down the count register
      if (loopStep) begin
        count_r <= count_r - 16'h0001; // RULE4
      end
      // string steps move both indexes by direction flag
      if (stringStep) begin
        srcIdx_r <= srcIdx_r + stepAmt; // RULE16
        destIdx_r <= destIdx_r + stepAmt; // RULE16
      end
    end
  end

  // string index step: minus one when direction set, plus one when clear
  assign stepAmt = status_r[DF_BIT] ? 16'hFFFF : 16'h0001; // RULE16

  // segment registers with reset values; software writes only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      segReg_r[0] <= CODESEG_RST; // RULE7
      segReg_r[1] <= SEG_RST; // RULE7
      segReg_r[2] <= SEG_RST;
      segReg_r[3] <= SEG_RST;
    end else if (regWrite && regAddr >= OFS_CODESEG && regAddr <= OFS_EXTRASEG) begin
      segReg_r[regAddr[1:0]] <= regWrData; // RULE6
    end
  end

  // instruction pointer: fetch advances, completion records next instruction
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      iptr_r <= IPTR_RST; // RULE9
      execIptr_r <= IPTR_RST;
    end else if (regWrite && regAddr == OFS_IPTR) begin
      iptr_r <= regWrData;
      execIptr_r <= regWrData;
    end else begin
      if (fetchStep) begin
        iptr_r <= iptr_r + 16'h0001; // RULE8
      end
      if (instrDone) begin
        execIptr_r <= execIptr_r + instrLength; // RULE8
      end
    end
  end

  // status word: alu posts flags, software writes only defined flag bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_r <= STATUS_RST; // RULE19
    end else if (regWrite && regAddr == OFS_STATUS) begin
      status_r <= (regWrData & STATUS_WMASK) | STATUS_RST; // RULE19 RULE20
    end else if (aluGo) begin
      status_r[CF_BIT] <= aluC; // RULE11 RULE23
      status_r[PF_BIT] <= aluP; // RULE14 RULE23
      status_r[AF_BIT] <= aluA; // RULE10 RULE23
      status_r[ZF_BIT] <= aluZ; // RULE15 RULE23
      status_r[SF_BIT] <= aluS; // RULE13 RULE23
      status_r[OF_BIT] <= aluO; // RULE12 RULE23
    end
  end

  // read data one cycle after the strobe; non-memory values captured at the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdPend_r <= 1'b0;
      rdFromMem_r <= 1'b0;
      rdHold_r <= 16'h0000;
      rdByte_r <= 2'b00;
    end else begin
      rdPend_r <= regRead;
      rdFromMem_r <= regRead && isGeneral(regAddr) && memRdAddr inside {3'd3, 3'd4, 3'd5};
      rdByte_r <= {regAddr[4] & regAddr[2], regAddr[4] & ~regAddr[2]};
      if (regAddr >= OFS_CODESEG && regAddr <= OFS_EXTRASEG) begin
        rdHold_r <= segReg_r[regAddr[1:0]];
      end else if (regAddr == OFS_IPTR) begin
        rdHold_r <= execIptr_r;
      end else if (regAddr == OFS_STATUS) begin
        rdHold_r <= status_r;
      end else if (isGeneral(regAddr)) begin
        rdHold_r <= mirrorOf(memRdAddr);
      end else begin
        rdHold_r <= 16'h0000;
      end
    end
  end

  // read mux; byte reads return the half in the low bits
  always_comb begin
    regRdData = 16'h0000;
    if (rdPend_r) begin
      regRdData = rdFromMem_r ? memRd : rdHold_r;
      regRdData = rdByte_r[1] ? {8'h00, regRdData[15:8]} : rdByte_r[0] ? {8'h00, regRdData[7:0]} : regRdData;
    end
  end

  // address forming, interrupt decisions and implicit-operand outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      physAddr <= 20'h00000;
      fetchAddr <= 20'h00000;
      savedIptr <= 16'h0000;
      takeInterrupt <= 1'b0;
      singleStepTrap <= 1'b0;
      overflowTrap <= 1'b0;
      shiftCount <= 8'h00;
      countZero <= 1'b0;
    end else begin
      physAddr <= {segReg_r[addrSeg], 4'h0} + {4'h0, addrOffset}; // RULE21 RULE22
      fetchAddr <= {segReg_r[0], 4'h0} + {4'h0, iptr_r}; // RULE9 RULE22
      savedIptr <= execIptr_r; // RULE8
      takeInterrupt <= (maskableReq && status_r[IF_BIT]) || softIntReq || nmiReq; // RULE17
      singleStepTrap <= instrDone && status_r[TF_BIT]; // RULE18
      overflowTrap <= overflowTrapInstr && status_r[OF_BIT]; // RULE12
      shiftCount <= count_r[7:0]; // RULE4
      countZero <= (count_r == 16'h0000); // RULE4
    end
  end

  // checks on reset values, flags, interrupts, traps and the physical address
  a_reset_codeseg: assert property (@(posedge clk_sys) reset |=> segReg_r[0] == CODESEG_RST) // RULE7
    else $error("code segment not all ones after reset");
  a_reset_status: assert property (@(posedge clk_sys) reset |=> status_r == STATUS_RST) // RULE19
    else $error("status word not F000 after reset");
  a_reset_iptr: assert property (@(posedge clk_sys) reset |=> iptr_r == IPTR_RST) // RULE9
    else $error("instruction pointer not cleared by reset");
  a_zero_flag: assert property (@(posedge clk_sys) disable iff (reset)
    aluGo && !regWrite |=> status_r[ZF_BIT] == ($past(aluRes) == 16'h0000)) // RULE15
    else $error("zero flag does not match result");
  a_sign_flag: assert property (@(posedge clk_sys) disable iff (reset)
    aluGo && !regWrite && !aluByte |=> status_r[SF_BIT] == $past(aluRes[15])) // RULE13
    else $error("sign flag does not match result top bit");
  a_parity_flag: assert property (@(posedge clk_sys) disable iff (reset)
    aluGo && !regWrite |=> status_r[PF_BIT] == ~^$past(aluRes[7:0])) // RULE14
    else $error("parity flag wrong");
  a_ie_gate: assert property (@(posedge clk_sys) disable iff (reset)
    maskableReq && !softIntReq && !nmiReq && !status_r[IF_BIT] |=> !takeInterrupt) // RULE17
    else $error("maskable request taken while disabled");
  a_nmi_pass: assert property (@(posedge clk_sys) disable iff (reset)
    nmiReq |=> takeInterrupt) // RULE17
    else $error("non-maskable request not taken");
  a_step_trap: assert property (@(posedge clk_sys) disable iff (reset)
    instrDone && status_r[TF_BIT] |=> singleStepTrap) // RULE18
    else $error("single-step trap missing");
  a_phys_addr: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> physAddr == (({$past(segReg_r[addrSeg]), 4'h0} + {4'h0, $past(addrOffset)}) & 20'hFFFFF)) // RULE22
    else $error("physical address wrong");
  c_alu_op: cover property (@(posedge clk_sys) aluGo && aluOp == ALU_ADD);
  c_string_dec: cover property (@(posedge clk_sys) stringStep && status_r[DF_BIT]);
  c_step: cover property (@(posedge clk_sys) singleStepTrap);
  c_byte_write: cover property (@(posedge clk_sys) regWrite && regAddr >= OFS_HIGHBYTE);
endmodule : cpu_architectural_registers
`default_nettype wire

// ==== tb/exec_unit_model.sv ====
// execution and bus interface unit model: drives the core's operation, address and interrupt inputs
// assumes the bench calls its tasks; every signal changes just after a rising edge of clk_sys
`default_nettype none
module exec_unit_model
  import arch_regs_pkg::*;
(
  input wire logic clk_sys,
  output var logic aluGo,
  output var alu_op_t aluOp,
  output var logic aluByte,
  output var logic [2:0] aluDest,
  output var logic [15:0] aluOperand,
  output var logic stringStep,
  output var logic loopStep,
  output var logic instrDone,
  output var logic [15:0] instrLength,
  output var logic fetchStep,
  output var logic overflowTrapInstr,
  output var logic [1:0] addrSeg,
  output var logic [15:0] addrOffset,
  output var logic maskableReq,
  output var logic softIntReq,
  output var logic nmiReq
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle levels from time zero
  initial begin
    aluGo = 1'b0;
    aluOp = ALU_ADD;
    aluByte = 1'b0;
    aluDest = 3'h0;
    aluOperand = 16'h0000;
    {stringStep, loopStep, instrDone, fetchStep, overflowTrapInstr} = 5'h00;
    instrLength = 16'h0000;
    addrSeg = 2'h0;
    addrOffset = 16'h0000;
    {maskableReq, softIntReq, nmiReq} = 3'h0;
  end
  // one alu operation, strobe held for exactly one edge
  task automatic alu(input alu_op_t op, input logic b, input logic [2:0] d, input logic [15:0] v);
    @(posedge clk_sys);
    aluGo <= 1'b1;
    aluOp <= op;
    aluByte <= b;
    aluDest <= d;
    aluOperand <= v;
    @(posedge clk_sys);
    aluGo <= 1'b0;
  endtask : alu
  // one-cycle step pulse: 0 string, 1 loop, 2 fetch, 3 overflow trap, 4 instruction done
  task automatic step(input int k, input logic [15:0] len);
    @(posedge clk_sys);
    stringStep <= (k == 0);
    loopStep <= (k == 1);
    fetchStep <= (k == 2);
    overflowTrapInstr <= (k == 3);
    instrDone <= (k == 4);
    instrLength <= len;
    @(posedge clk_sys);
    {stringStep, loopStep, fetchStep, overflowTrapInstr, instrDone} <= 5'h00;
  endtask : step
  // address request and interrupt request levels
  task automatic level(input logic [1:0] s, input logic [15:0] o, input logic m, input logic w, input logic n);
    @(posedge clk_sys);
    addrSeg <= s;
    addrOffset <= o;
    maskableReq <= m;
    softIntReq <= w;
    nmiReq <= n;
  endtask : level
endmodule : exec_unit_model
`default_nettype wire

// ==== tb/test_cpu_architectural_registers.sv ====
// self-checking bench for the architectural register block: register port tasks and scenarios
// assumes the execution unit model drives the operation, address and interrupt inputs
`default_nettype none
module test_cpu_architectural_registers
  import arch_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrite = 1'b0, regRead = 1'b0;
  logic [15:0] regRdData, savedIptr, aluOperand, instrLength, addrOffset;
  logic [19:0] physAddr, fetchAddr;
  logic takeInterrupt, singleStepTrap, overflowTrap, countZero;
  logic [7:0] shiftCount;
  logic aluGo, aluByte, stringStep, loopStep, instrDone, fetchStep, overflowTrapInstr;
  alu_op_t aluOp;
  logic [2:0] aluDest;
  logic [1:0] addrSeg;
  logic maskableReq, softIntReq, nmiReq;
  int errors = 0, testsRun = 0;
  cpu_architectural_registers cpu_architectural_registers_inst (.clk_sys, .reset, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .aluGo, .aluOp, .aluByte, .aluDest, .aluOperand, .stringStep,
    .loopStep, .instrDone, .instrLength, .fetchStep, .overflowTrapInstr, .addrSeg, .addrOffset,
    .maskableReq, .softIntReq, .nmiReq, .physAddr, .fetchAddr, .savedIptr, .takeInterrupt,
    .singleStepTrap, .overflowTrap, .shiftCount, .countZero);
  exec_unit_model exec_unit_model_inst (.clk_sys, .aluGo, .aluOp, .aluByte, .aluDest, .aluOperand,
    .stringStep, .loopStep, .instrDone, .instrLength, .fetchStep, .overflowTrapInstr, .addrSeg,
    .addrOffset, .maskableReq, .softIntReq, .nmiReq);
  // core clock
  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  // compare and count
  task automatic check(input string n, input logic [19:0] seen, input logic [19:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // one-cycle register write
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  // one-cycle register read, data taken in the following cycle under a mask
  task automatic rdc(input string n, input logic [4:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hFFFF);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    check(n, {4'h0, regRdData & m}, {4'h0, exp});
  endtask : rdc
  // let some cycles pass, then settle past the edge
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  // load accumulator, run one operation, check result and flags
  task automatic aluc(input alu_op_t op, input logic b, input logic [15:0] a, input logic [15:0] v,
                      input logic [15:0] r, input logic [15:0] m, input logic [15:0] s);
    wr(OFS_ACCUM, a);
    exec_unit_model_inst.alu(op, b, 3'h0, v);
    rdc("alu result", OFS_ACCUM, r);
    rdc("alu flags", OFS_STATUS, s, m);
  endtask : aluc
  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end
  // scenario sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rdc("code seg", OFS_CODESEG, 16'hFFFF);
    rdc("stack seg", OFS_STACKSEG, 16'h0000);
    rdc("data seg", OFS_DATASEG, 16'h0000);
    rdc("extra seg", OFS_EXTRASEG, 16'h0000);
    rdc("instr ptr", OFS_IPTR, 16'h0000);
    rdc("status", OFS_STATUS, 16'hF000);
    check("fetch addr", fetchAddr, 20'hFFFF0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(5'(i), 16'h1111 * 16'(i + 1));
    end
    for (int i = 0; i < 8; i++) begin
      rdc("general", 5'(i), 16'h1111 * 16'(i + 1));
    end
    wr(5'h12, 16'h00AB);
    wr(5'h16, 16'h00CD);
    rdc("datax word", OFS_DATAX, 16'hCDAB);
    rdc("datax high", 5'h16, 16'h00CD);
    wr(5'h13, 16'h0077);
    rdc("base word", OFS_BASE, 16'h4477);
    rdc("stack ptr", OFS_STACKP, 16'h5555);
    rdc("unmapped", 5'h0E, 16'h0000);
    $display("test general done");
    aluc(ALU_ADD, 1'b0, 16'hFFFF, 16'h0001, 16'h0000, 16'hFFFF, 16'hF055);
    aluc(ALU_ADD, 1'b0, 16'h7FFF, 16'h7FFF, 16'hFFFE, 16'hFFFF, 16'hF890);
    aluc(ALU_SUB, 1'b0, 16'h0000, 16'h0001, 16'hFFFF, 16'hFFFF, 16'hF095);
    aluc(ALU_ADD, 1'b1, 16'h12F0, 16'h0010, 16'h1200, 16'hFFFF, 16'hF045);
    aluc(ALU_AND, 1'b0, 16'hF0F0, 16'h0F0F, 16'h0000, 16'h00C4, 16'h0044);
    aluc(ALU_OR, 1'b0, 16'h4000, 16'h8003, 16'hC003, 16'h00C4, 16'h0084);
    aluc(ALU_XOR, 1'b0, 16'hC003, 16'hC003, 16'h0000, 16'h00C4, 16'h0044);
    wr(OFS_STATUS, 16'h0001);
    aluc(ALU_RCL, 1'b0, 16'h8000, 16'h0000, 16'h0001, 16'h0001, 16'h0001);
    wr(OFS_STATUS, 16'hFFFF);
    rdc("status mask", OFS_STATUS, 16'hFFD5);
    $display("test flags done");
    wr(OFS_STATUS, 16'h0000);
    wr(OFS_SRCIDX, 16'h0010);
    wr(OFS_DESTIDX, 16'h0020);
    exec_unit_model_inst.step(0, 16'h0000);
    rdc("src up", OFS_SRCIDX, 16'h0011);
    rdc("dest up", OFS_DESTIDX, 16'h0021);
    wr(OFS_STATUS, 16'h0400);
    exec_unit_model_inst.step(0, 16'h0000);
    exec_unit_model_inst.step(0, 16'h0000);
    rdc("src down", OFS_SRCIDX, 16'h000F);
    rdc("dest down", OFS_DESTIDX, 16'h001F);
    $display("test direction done");
    wr(OFS_COUNT, 16'h0002);
    idle(3);
    check("shift count", {12'h000, shiftCount}, 20'h00002);
    check("count zero", {19'h0, countZero}, 20'h00000);
    exec_unit_model_inst.step(1, 16'h0000);
    exec_unit_model_inst.step(1, 16'h0000);
    idle(3);
    check("count zero", {19'h0, countZero}, 20'h00001);
    check("shift count", {12'h000, shiftCount}, 20'h00000);
    $display("test count done");
    for (int i = 0; i < 16; i++) begin
      wr(OFS_STATUS, {6'h00, i[3], 9'h000});
      exec_unit_model_inst.level(2'h0, 16'h0000, i[0], i[1], i[2]);
      idle(3);
      check("take irq", {19'h0, takeInterrupt}, {19'h0, i[2] | i[1] | (i[0] & i[3])});
    end
    exec_unit_model_inst.level(2'h0, 16'h0000, 1'b0, 1'b0, 1'b0);
    wr(OFS_STATUS, 16'h0900);
    exec_unit_model_inst.step(4, 16'h0001);
    #1;
    check("step trap", {19'h0, singleStepTrap}, 20'h00001);
    exec_unit_model_inst.step(3, 16'h0000);
    #1;
    check("ovf trap", {19'h0, overflowTrap}, 20'h00001);
    wr(OFS_STATUS, 16'h0000);
    exec_unit_model_inst.step(4, 16'h0001);
    #1;
    check("no step trap", {19'h0, singleStepTrap}, 20'h00000);
    exec_unit_model_inst.step(3, 16'h0000);
    #1;
    check("no ovf trap", {19'h0, overflowTrap}, 20'h00000);
    $display("test interrupts done");
    wr(OFS_IPTR, 16'h0100);
    repeat (3) exec_unit_model_inst.step(2, 16'h0000);
    exec_unit_model_inst.step(4, 16'h0002);
    idle(2);
    check("fetch wrap", fetchAddr, 20'h000F3);
    check("saved ptr", {4'h0, savedIptr}, 20'h00102);
    rdc("exec ptr", OFS_IPTR, 16'h0102);
    wr(OFS_DATASEG, 16'h1234);
    wr(OFS_EXTRASEG, 16'hFFFF);
    exec_unit_model_inst.level(2'h2, 16'h0005, 1'b0, 1'b0, 1'b0);
    idle(2);
    check("phys data", physAddr, 20'h12345);
    exec_unit_model_inst.level(2'h3, 16'h0020, 1'b0, 1'b0, 1'b0);
    idle(2);
    check("phys extra", physAddr, 20'h00010);
    exec_unit_model_inst.level(2'h0, 16'hFFFF, 1'b0, 1'b0, 1'b0);
    idle(2);
    check("phys code", physAddr, 20'h0FFEF);
    $display("test address done");
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rdc("code seg again", OFS_CODESEG, 16'hFFFF);
    rdc("data seg again", OFS_DATASEG, 16'h0000);
    rdc("status again", OFS_STATUS, 16'hF000);
    $display("test second reset done");
    end_of_test();
  end
endmodule : test_cpu_architectural_registers
`default_nettype wire
